/* File: shared/dspmc_pkg.sv */
// shared constants, states and carriers for the deep stop power mode control
package dspmc_pkg;

    // apb register byte offsets
    localparam logic [7:0] DSPMC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] DSPMC_OFS_CLKGEN  = 8'h04;
    localparam logic [7:0] DSPMC_OFS_STATUS  = 8'h08;

    // control register fields
    localparam int DSPMC_CTRL_STOP_ALLOW   = 0;
    localparam int DSPMC_CTRL_PPD_SELECT   = 1;
    localparam int DSPMC_CTRL_UV_ON        = 2;
    localparam int DSPMC_CTRL_UV_IN_STOP   = 3;
    localparam int DSPMC_CTRL_UV_TRIP_HIGH = 4;
    localparam int DSPMC_CTRL_RTC_ON       = 5;
    localparam int DSPMC_CTRL_ADC_ASYNC    = 6;
    localparam int DSPMC_CTRL_W            = 7;
    localparam logic [6:0] DSPMC_CTRL_RST  = 7'h04;

    // clock generator control fields
    localparam int DSPMC_CG_INT_REF_ON     = 0;
    localparam int DSPMC_CG_INT_REF_KEEP   = 1;
    localparam int DSPMC_CG_EXT_REF_ON     = 2;
    localparam int DSPMC_CG_EXT_REF_KEEP   = 3;
    localparam int DSPMC_CG_RANGE_HIGH     = 4;
    localparam int DSPMC_CG_W              = 5;
    localparam logic [4:0] DSPMC_CG_RST    = 5'h00;

    // status register fields
    localparam int DSPMC_ST_FLAG           = 0;
    localparam int DSPMC_ST_ACK            = 1;
    localparam int DSPMC_ST_MODE_LO        = 2;
    localparam int DSPMC_ST_LATCHED        = 4;

    // power-on style reset stretch after a deep stop wake
    localparam int          DSPMC_WAKE_RST_CYC = 16;
    localparam logic [15:0] DSPMC_RESET_VECTOR = 16'hfffe;

    typedef enum logic [1:0] {
        DSPMC_RUN        = 2'b00,
        DSPMC_LIGHT_STOP = 2'b01,
        DSPMC_DEEP_STOP  = 2'b10,
        DSPMC_WAKE_RST   = 2'b11
    } dspmc_state_e;

    // power and clock controls to the rest of the chip
    typedef struct packed {
        logic core_pwr_on;     // cpu, nvm, port regs, serial, timer, can
        logic ram_pwr_on;
        logic periph_clk_on;
        logic debug_clk_on;
        logic comparator_on;
        logic adc_on;
        logic int_ref_on;
        logic crystal_oscillator_on;
        logic rtc_on;
        logic vreg_full;
    } dspmc_pwr_s;

endpackage : dspmc_pkg

/* File: src/dspmc_pin_hold.sv */
// per-pin hold latch and port/peripheral pin mux
`timescale 1ns/1ps
module dspmc_pin_hold
    import dspmc_pkg::*;
#(
    parameter int NPIN = 8
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            hold_closed,
    input  wire logic [NPIN-1:0] port_do,
    input  wire logic [NPIN-1:0] port_oe,
    input  wire logic [NPIN-1:0] periph_en,
    input  wire logic [NPIN-1:0] periph_do,
    input  wire logic [NPIN-1:0] periph_oe,
    output logic      [NPIN-1:0] pin_o,
    output logic      [NPIN-1:0] pin_oe
);

    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            // while closed the flop simply keeps its value
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pin_o[i]  <= 1'b0;
                    pin_oe[i] <= 1'b0;
                end else if (!hold_closed) begin
                    pin_o[i]  <= periph_en[i] ? periph_do[i] : port_do[i];
                    pin_oe[i] <= periph_en[i] ? periph_oe[i] : port_oe[i];
                end
            end
        end
    endgenerate

    a_pin_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hold_closed |=> $stable(pin_o) && $stable(pin_oe))
        else $error("pin state moved while hold latch closed");

    a_pin_follow_port: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !hold_closed && periph_en == '0 |=> pin_o == $past(port_do))
        else $error("open pin not driven from port register");

endmodule : dspmc_pin_hold

/* File: src/dspmc_top.sv */
// deep stop power mode control: mode selection, wake, pin hold, apb regs
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dspmc_top
    import dspmc_pkg::*;
#(
    parameter int NPIN = 8,
    parameter int AW   = 8
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [AW-1:0]   paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // cpu and wake sources
    input  wire logic            stop_exec,
    input  wire logic            debug_in_stop_allow,
    input  wire logic            ext_reset_req,
    input  wire logic            rtc_wake,
    input  wire logic            light_wake_irq,
    input  wire logic            supply_below_trip,
    // pin sources
    input  wire logic [NPIN-1:0] port_do,
    input  wire logic [NPIN-1:0] port_oe,
    input  wire logic [NPIN-1:0] periph_en,
    input  wire logic [NPIN-1:0] periph_do,
    input  wire logic [NPIN-1:0] periph_oe,
    // outputs to the chip
    output logic [NPIN-1:0]      pin_o,
    output logic [NPIN-1:0]      pin_oe,
    output dspmc_pwr_s           pwr,
    output logic                 illegal_op_reset,
    output logic                 chip_reset,
    output logic                 uv_reset_on,
    output logic                 uv_trip_high,
    output logic                 fetch_vector,
    output logic [15:0]          fetch_addr
);

    dspmc_state_e                   state_q;
    logic [DSPMC_CTRL_W-1:0]        ctrl_q;
    logic [DSPMC_CG_W-1:0]          cg_q;
    logic                           flag_q;
    logic                           latched_q;
    logic [4:0]                     wake_cnt_q;
    dspmc_pwr_s                     pwr_q;
    logic [31:0]                    prdata_q;
    logic                           pready_q;
    logic                           pslverr_q;
    logic                           illegal_q;
    logic                           chip_reset_q;
    logic                           fetch_q;

    logic uv_full_stop;
    logic deep_pick;
    logic wr_acc;
    logic ack_wr;
    logic wake_deep;
    logic wake_done;
    logic mapped;

    assign uv_full_stop = ctrl_q[DSPMC_CTRL_UV_ON] &
                          ctrl_q[DSPMC_CTRL_UV_IN_STOP];
    assign deep_pick    = !debug_in_stop_allow && !uv_full_stop &&
                          ctrl_q[DSPMC_CTRL_PPD_SELECT];
    assign wr_acc       = psel && penable && pready_q && pwrite;
    assign mapped       = paddr == AW'(DSPMC_OFS_CTRL) ||
                          paddr == AW'(DSPMC_OFS_CLKGEN) ||
                          paddr == AW'(DSPMC_OFS_STATUS);
    assign ack_wr       = wr_acc && paddr == AW'(DSPMC_OFS_STATUS) &&
                          pwdata[DSPMC_ST_ACK];
    // rtc counts only while enabled, so its wake is gated the same way
    assign wake_deep    = ext_reset_req ||
                          (rtc_wake && ctrl_q[DSPMC_CTRL_RTC_ON]);
    assign wake_done    = wake_cnt_q == 5'(DSPMC_WAKE_RST_CYC - 1) &&
                          !supply_below_trip;

    // mode sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DSPMC_RUN;
        end else begin
            case (state_q)
                DSPMC_RUN: begin
                    if (stop_exec && ctrl_q[DSPMC_CTRL_STOP_ALLOW]) begin
                        state_q <= deep_pick ? DSPMC_DEEP_STOP
                                             : DSPMC_LIGHT_STOP;
                    end
                end
                DSPMC_LIGHT_STOP: begin
                    if (ext_reset_req || light_wake_irq) begin
                        state_q <= DSPMC_RUN;
                    end
                end
                DSPMC_DEEP_STOP: begin
                    if (wake_deep) begin
                        state_q <= DSPMC_WAKE_RST;
                    end
                end
                DSPMC_WAKE_RST: begin
                    if (wake_done) begin
                        state_q <= DSPMC_RUN;
                    end
                end
                default: state_q <= DSPMC_RUN;
            endcase
        end
    end

    // reset stretch counter, saturates while the supply is still low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt_q <= 5'h00;
        end else if (state_q != DSPMC_WAKE_RST) begin
            wake_cnt_q <= 5'h00;
        end else if (wake_cnt_q != 5'(DSPMC_WAKE_RST_CYC - 1)) begin
            wake_cnt_q <= wake_cnt_q + 5'h01;
        end
    end

    // chip reset, illegal stop and vector fetch strobes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            illegal_q    <= 1'b0;
            chip_reset_q <= 1'b0;
            fetch_q      <= 1'b0;
        end else begin
            illegal_q    <= state_q == DSPMC_RUN && stop_exec &&
                            !ctrl_q[DSPMC_CTRL_STOP_ALLOW];
            chip_reset_q <= state_q == DSPMC_WAKE_RST && !wake_done;
            fetch_q      <= state_q == DSPMC_WAKE_RST && wake_done;
        end
    end

    // control registers; a deep stop wake returns them to reset values
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= DSPMC_CTRL_RST;
            cg_q   <= DSPMC_CG_RST;
        end else if (state_q == DSPMC_WAKE_RST) begin
            ctrl_q <= DSPMC_CTRL_RST;
            cg_q   <= DSPMC_CG_RST;
        end else if (wr_acc && paddr == AW'(DSPMC_OFS_CTRL)) begin
            ctrl_q <= pwdata[DSPMC_CTRL_W-1:0];
        end else if (wr_acc && paddr == AW'(DSPMC_OFS_CLKGEN)) begin
            cg_q   <= pwdata[DSPMC_CG_W-1:0];
        end
    end

    // recovery flag and pin hold survive the wake; set wins over ack
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q    <= 1'b0;
            latched_q <= 1'b0;
        end else begin
            if (state_q == DSPMC_WAKE_RST) begin
                flag_q <= 1'b1;
            end else if (ack_wr) begin
                flag_q <= 1'b0;
            end
            if (state_q == DSPMC_RUN && stop_exec &&
                ctrl_q[DSPMC_CTRL_STOP_ALLOW] && deep_pick) begin
                latched_q <= 1'b1;
            end else if (ack_wr && state_q == DSPMC_RUN) begin
                latched_q <= 1'b0;
            end
        end
    end

    // power domains and keep-alive decisions per mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= '{core_pwr_on: 1'b1, ram_pwr_on: 1'b1,
                       periph_clk_on: 1'b1, debug_clk_on: 1'b1,
                       comparator_on: 1'b1, adc_on: 1'b1,
                       int_ref_on: 1'b1, crystal_oscillator_on: 1'b1,
                       rtc_on: 1'b1, vreg_full: 1'b1};
        end else begin
            case (state_q)
                DSPMC_LIGHT_STOP: begin
                    pwr_q.core_pwr_on   <= 1'b1;
                    pwr_q.ram_pwr_on    <= 1'b1;
                    pwr_q.periph_clk_on <= 1'b0;
                    pwr_q.debug_clk_on  <= debug_in_stop_allow;
                    pwr_q.comparator_on <= ctrl_q[DSPMC_CTRL_UV_ON];
                    pwr_q.adc_on        <= ctrl_q[DSPMC_CTRL_ADC_ASYNC] &&
                                           ctrl_q[DSPMC_CTRL_UV_ON];
                    pwr_q.int_ref_on    <= cg_q[DSPMC_CG_INT_REF_ON] &&
                                           cg_q[DSPMC_CG_INT_REF_KEEP];
                    pwr_q.crystal_oscillator_on       <= cg_q[DSPMC_CG_EXT_REF_ON] &&
                                           cg_q[DSPMC_CG_EXT_REF_KEEP] &&
                                           (!cg_q[DSPMC_CG_RANGE_HIGH] ||
                                            ctrl_q[DSPMC_CTRL_UV_ON]);
                    pwr_q.rtc_on        <= ctrl_q[DSPMC_CTRL_RTC_ON];
                    pwr_q.vreg_full     <= ctrl_q[DSPMC_CTRL_UV_ON] ||
                                           debug_in_stop_allow;
                end
                DSPMC_DEEP_STOP: begin
                    pwr_q.core_pwr_on   <= 1'b0;
                    pwr_q.ram_pwr_on    <= 1'b1;
                    pwr_q.periph_clk_on <= 1'b0;
                    pwr_q.debug_clk_on  <= 1'b0;
                    pwr_q.comparator_on <= 1'b0;
                    pwr_q.adc_on        <= 1'b0;
                    pwr_q.int_ref_on    <= 1'b0;
                    pwr_q.crystal_oscillator_on       <= 1'b0;
                    pwr_q.rtc_on        <= ctrl_q[DSPMC_CTRL_RTC_ON];
                    pwr_q.vreg_full     <= ctrl_q[DSPMC_CTRL_UV_ON];
                end
                default: begin
                    pwr_q <= '{core_pwr_on: 1'b1, ram_pwr_on: 1'b1,
                               periph_clk_on: 1'b1, debug_clk_on: 1'b1,
                               comparator_on: 1'b1, adc_on: 1'b1,
                               int_ref_on: 1'b1, crystal_oscillator_on: 1'b1,
                               rtc_on: 1'b1, vreg_full: 1'b1};
                end
            endcase
        end
    end

    // apb: no wait state; read data is registered in the setup phase so it leaves a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            prdata_q  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == AW'(DSPMC_OFS_CTRL)) begin
                    prdata_q[DSPMC_CTRL_W-1:0] <= ctrl_q;
                end else if (paddr == AW'(DSPMC_OFS_CLKGEN)) begin
                    prdata_q[DSPMC_CG_W-1:0] <= cg_q;
                end else if (paddr == AW'(DSPMC_OFS_STATUS)) begin
                    prdata_q[DSPMC_ST_FLAG] <= flag_q;
                    prdata_q[DSPMC_ST_MODE_LO +: 2] <= state_q;
                    prdata_q[DSPMC_ST_LATCHED] <= latched_q;
                end
            end
        end
    end

    dspmc_pin_hold #(
        .NPIN (NPIN)
    ) u_pin_hold (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .hold_closed (latched_q),
        .port_do     (port_do),
        .port_oe     (port_oe),
        .periph_en   (periph_en),
        .periph_do   (periph_do),
        .periph_oe   (periph_oe),
        .pin_o       (pin_o),
        .pin_oe      (pin_oe)
    );

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign pwr              = pwr_q;
    assign illegal_op_reset = illegal_q;
    assign chip_reset       = chip_reset_q;
    assign uv_reset_on      = ctrl_q[DSPMC_CTRL_UV_ON];
    assign uv_trip_high     = ctrl_q[DSPMC_CTRL_UV_TRIP_HIGH];
    assign fetch_vector     = fetch_q;
    assign fetch_addr       = DSPMC_RESET_VECTOR;

    a_stop_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_RUN && stop_exec && !ctrl_q[DSPMC_CTRL_STOP_ALLOW]
        |=> illegal_op_reset && state_q == DSPMC_RUN)
        else $error("stop not refused while disallowed");

    a_deep_choice: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_RUN && stop_exec && ctrl_q[DSPMC_CTRL_STOP_ALLOW]
        |=> state_q == ($past(deep_pick) ? DSPMC_DEEP_STOP
                                         : DSPMC_LIGHT_STOP))
        else $error("wrong stop mode chosen");

    a_ram_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_DEEP_STOP |=> pwr.ram_pwr_on && !pwr.core_pwr_on)
        else $error("deep stop power domains wrong");

    a_wake_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_DEEP_STOP && wake_deep
        |=> state_q == DSPMC_WAKE_RST ##1 chip_reset)
        else $error("deep stop wake did not reset chip");

    a_wake_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_WAKE_RST |=> flag_q && latched_q)
        else $error("recovery flag not set on wake");

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flag_q && !ack_wr |=> flag_q)
        else $error("recovery flag cleared without ack");

    a_clk_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q inside {DSPMC_LIGHT_STOP, DSPMC_DEEP_STOP}
        |=> !pwr.periph_clk_on)
        else $error("peripheral clock running in stop");

    a_low_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_WAKE_RST && supply_below_trip
        |=> chip_reset && state_q == DSPMC_WAKE_RST && uv_reset_on
            && !uv_trip_high)
        else $error("reset released while supply low");

    a_regs_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DSPMC_WAKE_RST |=> ctrl_q == DSPMC_CTRL_RST
            && cg_q == DSPMC_CG_RST)
        else $error("control registers not reset on wake");

endmodule : dspmc_top

/* File: tb/dspmc_sw_model.sv */
// partner model: cpu software and wake event sources
`timescale 1ns/1ps
module dspmc_sw_model (
    input  wire logic       clk_sys,
    output logic            stop_exec,
    output logic            rtc_wake,
    output logic            ext_reset_req,
    output logic            light_wake_irq,
    output logic [7:0]      port_do,
    output logic [7:0]      port_oe,
    output logic [7:0]      periph_en,
    output logic [7:0]      periph_do,
    output logic [7:0]      periph_oe
);
    logic [3:0] ev_q;
    assign {light_wake_irq, ext_reset_req, rtc_wake, stop_exec} = ev_q;
    initial {ev_q, port_do, port_oe, periph_en, periph_do, periph_oe} = '0;
    // one-cycle event: 0 stop, 1 rtc, 2 ext reset, 3 wake irq
    task automatic pulse(input int k);
        @(posedge clk_sys);
        ev_q[k] <= 1'b1;
        @(posedge clk_sys);
        ev_q <= 4'h0;
    endtask : pulse
    // software restores ports and re-arms peripherals before the ack
    task automatic restore(input logic [39:0] v);
        @(posedge clk_sys);
        {port_do, port_oe, periph_en, periph_do, periph_oe} <= v;
    endtask : restore
endmodule : dspmc_sw_model

/* File: tb/tb.sv */
// testbench for the deep stop power mode control
`timescale 1ns/1ps
module tb;
    import dspmc_pkg::*;
    logic        clk_sys;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        debug_in_stop_allow;
    logic        supply_below_trip;
    logic [31:0] prdata;
    logic        pready, pslverr, illegal_op_reset, chip_reset;
    logic        uv_reset_on, uv_trip_high, fetch_vector;
    logic        stop_exec, rtc_wake, ext_reset_req, light_wake_irq;
    logic [7:0]  port_do, port_oe, periph_en, periph_do, periph_oe;
    logic [7:0]  pin_o, pin_oe;
    logic [15:0] fetch_addr;
    dspmc_pwr_s  pwr;
    int          fails = 0;
    int          cmp_count = 0;

    dspmc_top #(.NPIN(8), .AW(8)) uut (
        .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .stop_exec, .debug_in_stop_allow,
        .ext_reset_req, .rtc_wake, .light_wake_irq, .supply_below_trip,
        .port_do, .port_oe, .periph_en, .periph_do, .periph_oe,
        .pin_o, .pin_oe, .pwr, .illegal_op_reset, .chip_reset,
        .uv_reset_on, .uv_trip_high, .fetch_vector, .fetch_addr
    );
    dspmc_sw_model sw (
        .clk_sys, .stop_exec, .rtc_wake, .ext_reset_req, .light_wake_irq,
        .port_do, .port_oe, .periph_en, .periph_do, .periph_oe
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic bail();
        chk("wait", 32'h0, 32'h1);
        finish_test();
    endtask : bail

    // bus request is held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) bail();
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, r, exp);
    endtask : rd

    // 0 waits for the vector fetch, 1 for the reset stretch
    task automatic wait_for(input int w, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_sys);
            #1;
            if ((w == 0) ? fetch_vector : chip_reset) return;
        end
        bail();
    endtask : wait_for

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd("ctrl", DSPMC_OFS_CTRL, 32'h4);
        rd("clkgen", DSPMC_OFS_CLKGEN, 32'h0);
        rd("status", DSPMC_OFS_STATUS, 32'h0);
        wr(DSPMC_OFS_CTRL, 32'hffff_ffff);
        wr(DSPMC_OFS_CLKGEN, 32'hffff_ffff);
        rd("ctrl_rw", DSPMC_OFS_CTRL, 32'h7f);
        rd("clkgen_rw", DSPMC_OFS_CLKGEN, 32'h1f);
        chk("uv_out", {30'h0, uv_reset_on, uv_trip_high}, 32'h3);
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
        wr(DSPMC_OFS_CTRL, 32'h4);
        $display("test regs done");
    endtask : t_regs

    task automatic t_illegal();
        sw.pulse(0);
        #1;
        chk("illegal", {31'h0, illegal_op_reset}, 32'h1);
        settle(1);
        chk("illegal_end", {31'h0, illegal_op_reset}, 32'h0);
        chk("run_pwr", {22'h0, pwr}, 32'h3ff);
        $display("test illegal done");
    endtask : t_illegal

    task automatic t_light();
        wr(DSPMC_OFS_CTRL, 32'h6f);
        wr(DSPMC_OFS_CLKGEN, 32'h1f);
        sw.pulse(0);
        settle(2);
        chk("light_pwr", {22'h0, pwr}, 32'h33f);
        rd("light_st", DSPMC_OFS_STATUS, 32'h4);
        sw.pulse(3);
        settle(2);
        chk("light_exit", {22'h0, pwr}, 32'h3ff);
        @(posedge clk_sys);
        debug_in_stop_allow <= 1'b1;
        wr(DSPMC_OFS_CTRL, 32'h03);
        wr(DSPMC_OFS_CLKGEN, 32'h1d);
        sw.pulse(0);
        settle(2);
        chk("dbg_pwr", {22'h0, pwr}, 32'h341);
        rd("dbg_st", DSPMC_OFS_STATUS, 32'h4);
        sw.pulse(3);
        settle(2);
        @(posedge clk_sys);
        debug_in_stop_allow <= 1'b0;
        $display("test light done");
    endtask : t_light

    task automatic t_deep();
        sw.restore({8'ha5, 8'hff, 8'h00, 8'h00, 8'h00});
        wr(DSPMC_OFS_CTRL, 32'h27);
        chk("pins_run", {16'h0, pin_oe, pin_o}, 32'hffa5);
        sw.pulse(0);
        sw.restore({8'h3c, 8'h0f, 8'h00, 8'h00, 8'h00});
        settle(2);
        chk("deep_pwr", {22'h0, pwr}, 32'h103);
        chk("deep_pins", {16'h0, pin_oe, pin_o}, 32'hffa5);
        @(posedge clk_sys);
        supply_below_trip <= 1'b1;
        sw.pulse(1);
        settle(30);
        chk("uv_hold", {29'h0, chip_reset, uv_reset_on, uv_trip_high},
            32'h6);
        @(posedge clk_sys);
        supply_below_trip <= 1'b0;
        wait_for(0, 40);
        chk("vector", {15'h0, chip_reset, fetch_addr}, 32'hfffe);
        rd("ctrl_por", DSPMC_OFS_CTRL, 32'h4);
        rd("flag", DSPMC_OFS_STATUS, 32'h11);
        // sources change before the ack; pins must not follow them yet
        sw.restore({8'h5a, 8'hff, 8'h0f, 8'h33, 8'hf0});
        chk("held", {16'h0, pin_oe, pin_o}, 32'hffa5);
        wr(DSPMC_OFS_STATUS, 32'h2);
        rd("acked", DSPMC_OFS_STATUS, 32'h0);
        chk("pins_open", {16'h0, pin_oe, pin_o}, 32'hf053);
        wr(DSPMC_OFS_CTRL, 32'h07);
        sw.pulse(0);
        sw.pulse(1);
        settle(3);
        chk("rtc_off", {30'h0, chip_reset, pwr.core_pwr_on},
            32'h0);
        sw.pulse(2);
        wait_for(0, 60);
        rd("flag2", DSPMC_OFS_STATUS, 32'h11);
        wr(DSPMC_OFS_STATUS, 32'h2);
        $display("test deep done");
    endtask : t_deep

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {debug_in_stop_allow, supply_below_trip} = 2'b00;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_illegal();
        t_light();
        t_deep();
        finish_test();
    end
endmodule : tb
